// ### bench/sfs_flash_front_chk.sv
// Port checker for the serial flash front end
`timescale 1ns/10ps
`include "sfs_regs.svh"
module sfs_flash_front_chk (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic wp_n_i,
	input wire logic serial_in_line_i,
	input wire logic dual_lane_zero_o,
	input wire logic dual_lane_zero_oe_n_o,
	input wire logic dual_lane_one_o,
	input wire logic dual_lane_one_oe_n_o,
	input wire logic busy_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Busy lengths of status write, erase and page program
	localparam logic [8:0] BUSY_WSR   = 9'(`SFS_BUSY_CYC + 1);
	localparam logic [8:0] BUSY_ERASE = 9'(`SFS_BUSY_CYC + 2);
	localparam logic [8:0] BUSY_PROG  = 9'(`SFS_BUSY_CYC + `SFS_PAGE_BYTES + 1);
	logic [8:0] busy_cnt_q;
	// Busy length counter, saturating
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			busy_cnt_q <= 9'h000;
		else if (!busy_o)
			busy_cnt_q <= 9'h000;
		else if (busy_cnt_q != 9'h1FF)
			busy_cnt_q <= busy_cnt_q + 9'h001;
	end
	property p_rel_one; cs_n_i [*6] |-> dual_lane_one_oe_n_o; endproperty
	property p_rel_zero; cs_n_i [*6] |-> dual_lane_zero_oe_n_o; endproperty
	property p_one_fall;
		!dual_lane_one_oe_n_o && !$past(dual_lane_one_oe_n_o) && $changed(dual_lane_one_o) |-> !sck_i;
	endproperty
	property p_zero_fall;
		!dual_lane_zero_oe_n_o && !$past(dual_lane_zero_oe_n_o) && $changed(dual_lane_zero_o) |-> !sck_i;
	endproperty
	property p_zero_with_one; !dual_lane_zero_oe_n_o |-> !dual_lane_one_oe_n_o; endproperty
	property p_busy_desel; $rose(busy_o) |-> cs_n_i && $past(cs_n_i, 2); endproperty
	property p_busy_len;
		$fell(busy_o) |-> busy_cnt_q == BUSY_WSR || busy_cnt_q == BUSY_ERASE || busy_cnt_q == BUSY_PROG;
	endproperty
	property p_quiet_op; $fell(cs_n_i) |-> dual_lane_one_oe_n_o [*8]; endproperty
	a_rel_one: assert property (p_rel_one) else $error("lane one driven while deselected");
	a_rel_zero: assert property (p_rel_zero) else $error("lane zero driven while deselected");
	a_one_fall: assert property (p_one_fall) else $error("lane one moved off falling edge");
	a_zero_fall: assert property (p_zero_fall) else $error("lane zero moved off falling edge");
	a_zero_with_one: assert property (p_zero_with_one) else $error("lane zero driven alone");
	a_busy_desel: assert property (p_busy_desel) else $error("busy began while selected");
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	a_quiet_op: assert property (p_quiet_op) else $error("output driven during opcode");
	c_dual: cover property (!dual_lane_zero_oe_n_o);
	c_busy: cover property ($rose(busy_o));
	c_mode3: cover property ($fell(cs_n_i) && sck_i);
endmodule // sfs_flash_front_chk
bind sfs_flash_front sfs_flash_front_chk u_chk (.ref_clk_i, .sys_rst_i, .sck_i, .cs_n_i, .wp_n_i,
	.serial_in_line_i, .dual_lane_zero_o, .dual_lane_zero_oe_n_o, .dual_lane_one_o, .dual_lane_one_oe_n_o, .busy_o);

// ### bench/sfs_flash_front_tb.sv
// Self-checking bench for the serial flash front end
`timescale 1ns/10ps
`include "sfs_regs.svh"
module sfs_flash_front_tb;
	typedef logic [7:0] sfs_bytes_type [$];
	localparam logic [127:0] ID = 128'h5A5A1234_0F0F9876_C3C32468_A5A51357; // Arbitrary value
	logic          ref_clk_i;
	logic          sys_rst_i;
	logic          wp_n_i;
	logic          sck, cs_n, mosi, io0, io1, z_o, z_oe_n, o_o, o_oe_n, busy;
	int            error_cnt;
	int            comparisons;
	sfs_bytes_type rd;
	logic [7:0]    r, d0, d1, d2, e;
	logic [23:0]   a;
	logic [7:0]    ops [4];
	assign io0 = z_oe_n ? mosi : z_o;
	assign io1 = o_oe_n ? ~mosi : o_o;
	sfs_flash_front #(.UNIQUE_ID(ID)) u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck),
		.cs_n_i(cs_n), .wp_n_i(wp_n_i), .serial_in_line_i(io0), .dual_lane_zero_o(z_o),
		.dual_lane_zero_oe_n_o(z_oe_n), .dual_lane_one_o(o_o), .dual_lane_one_oe_n_o(o_oe_n), .busy_o(busy));
	sfs_spi_master u_m (.lane_zero_i(io0), .lane_one_i(io1), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
	function automatic sfs_bytes_type adr(input logic [7:0] op, input logic [23:0] ad);
		return {op, ad[23:16], ad[15:8], ad[7:0]};
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One frame, random mode, then wait out busy
	task automatic cmd(input sfs_bytes_type tx, input int nrd, input logic dual, input int last = 8);
		rd = {};
		u_m.start(1'($urandom % 2));
		foreach (tx[i]) u_m.xfer(tx[i], (i == tx.size() - 1) ? last : 8, 1'b0, r);
		repeat (nrd) begin
			u_m.xfer(8'h00, 8, dual, r);
			rd.push_back(r);
		end
		u_m.stop();
		for (int k = 0; k < 300 && busy !== 1'b0; k++) @(posedge ref_clk_i);
		check("busy", {7'h00, busy}, 8'h00);
	endtask
	task automatic status(input logic [7:0] exp);
		cmd({`SFS_OP_RDSR}, 1, 1'b0);
		check("status", rd[0], exp);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		#3000000;
		error_cnt++;
		final_report();
	end
	initial begin
		error_cnt = 0;
		comparisons = 0;
		sys_rst_i = 1'b1;
		wp_n_i = 1'b1;
		ops = '{`SFS_OP_SE, `SFS_OP_BE32, `SFS_OP_BE64, `SFS_OP_CE};
		r = 8'($urandom(32'h909E1D15));
		repeat (4) @(posedge ref_clk_i);
		#1 sys_rst_i = 1'b0;
		// ----------------------------------------
		// Every erase size, top byte first
		// ----------------------------------------
		for (int j = 0; j < 4; j++) begin
			a = (j == 0) ? 24'h07FFFF : 24'($urandom % 32'h80000);
			cmd({`SFS_OP_WREN}, 0, 1'b0);
			cmd({adr(`SFS_OP_PP, a), 8'h00}, 0, 1'b0);
			cmd(adr(`SFS_OP_READ, a), 1, 1'b0);
			check("programmed", rd[0], 8'h00);
			cmd({`SFS_OP_WREN}, 0, 1'b0);
			if (j == 3)
				cmd({ops[j]}, 0, 1'b0);
			else
				cmd(adr(ops[j], a), 0, 1'b0);
			cmd(adr(`SFS_OP_READ, a), 1, 1'b0);
			check("erased", rd[0], 8'hFF);
		end
		$display("test erase done");
		// ----------------------------------------
		// Page wrap, overwrite, dual and fast read
		// ----------------------------------------
		a = (24'($urandom % 32'h80000) & 24'h07FF00) | 24'h0000FE;
		{d0, d1, d2, e} = $urandom;
		cmd({`SFS_OP_WREN}, 0, 1'b0);
		cmd(adr(`SFS_OP_SE, a), 0, 1'b0);
		cmd({`SFS_OP_WREN}, 0, 1'b0);
		status(8'h02);
		cmd({adr(`SFS_OP_PP, a), d0, d1, d2}, 0, 1'b0);
		status(8'h00);
		cmd(adr(`SFS_OP_READ, a & 24'h07FF00), 1, 1'b0);
		check("wrapped", rd[0], d2);
		cmd({`SFS_OP_WREN}, 0, 1'b0);
		cmd({adr(`SFS_OP_PP, a), e}, 0, 1'b0);
		cmd({adr(`SFS_OP_DREAD, a), 8'h00}, 2, 1'b1);
		check("dual0", rd[0], d0 & e);
		check("dual1", rd[1], d1);
		cmd({adr(`SFS_OP_FREAD, a), 8'h00}, 2, 1'b0);
		check("fast0", rd[0], d0 & e);
		check("fast1", rd[1], d1);
		$display("test page done");
		// ----------------------------------------
		// Erase cut short of a byte boundary
		// ----------------------------------------
		cmd({`SFS_OP_WREN}, 0, 1'b0);
		cmd(adr(`SFS_OP_SE, a), 0, 1'b0, 5);
		cmd(adr(`SFS_OP_READ, a & 24'h07FF00), 1, 1'b0);
		check("partial", rd[0], d2);
		cmd({`SFS_OP_WRDI}, 0, 1'b0);
		$display("test boundary done");
		// ----------------------------------------
		// Status lock with protect pin
		// ----------------------------------------
		cmd({`SFS_OP_WREN}, 0, 1'b0);
		cmd({`SFS_OP_WRSR, 8'h80}, 0, 1'b0);
		status(8'h80);
		wp_n_i = 1'b0;
		cmd({`SFS_OP_WREN}, 0, 1'b0);
		cmd({`SFS_OP_WRSR, 8'h00}, 0, 1'b0);
		status(8'h82);
		wp_n_i = 1'b1;
		cmd({`SFS_OP_WRSR, 8'h00}, 0, 1'b0);
		status(8'h00);
		$display("test lock done");
		// ----------------------------------------
		// Select held low through a reset
		// ----------------------------------------
		u_m.start(1'b0);
		@(posedge ref_clk_i);
		#1 sys_rst_i = 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1 sys_rst_i = 1'b0;
		u_m.xfer(`SFS_OP_WREN, 8, 1'b0, r);
		u_m.stop();
		status(8'h00);
		cmd({`SFS_OP_WREN}, 0, 1'b0);
		status(8'h02);
		cmd({`SFS_OP_WRDI}, 0, 1'b0);
		status(8'h00);
		$display("test select gate done");
		// ----------------------------------------
		// Unique identifier
		// ----------------------------------------
		cmd({`SFS_OP_UID, 8'h00, 8'h00, 8'h00, 8'h00}, 16, 1'b0);
		for (int i = 0; i < 16; i++) check("uid", rd[i], ID[127-8*i -: 8]);
		$display("test uid done");
		final_report();
	end
endmodule // sfs_flash_front_tb

// ### bench/sfs_spi_master.sv
// Serial bus master model facing the flash front end
`timescale 1ns/10ps
module sfs_spi_master (
	input  wire logic lane_zero_i,
	input  wire logic lane_one_i,
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      mosi_o
);
	logic mode3_q;
	initial begin
		mode3_q = 1'b0;
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	task automatic start(input logic m3);
		mode3_q = m3;
		sck_o = m3;
		#437;
		cs_n_o = 1'b0;
		#400;
	endtask
	task automatic xfer(input logic [7:0] tx, input int nbits, input logic dual, output logic [7:0] rx);
		int step;
		step = dual ? 2 : 1;
		rx = 8'h00;
		for (int i = 0; i < nbits; i += step) begin
			sck_o = 1'b0;
			mosi_o = dual ? ~mosi_o : tx[7-i];
			#400;
			sck_o = 1'b1;
			rx = dual ? {rx[5:0], lane_one_i, lane_zero_i} : {rx[6:0], lane_one_i};
			#400;
		end
	endtask
	task automatic stop;
		if (!mode3_q) begin
			sck_o = 1'b0;
			#400;
		end
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#800;
	endtask
endmodule // sfs_spi_master

// ### rtl/sfs_flash_front.sv
// Serial flash bus front end with array, status and protection
// Function
// - Sample input on rising clock while selected
// - Change output on falling clock edges
// - Dual read drives lane zero and one
// - Deselected ignores clock, outputs released
// - Need select falling edge after power-up
// - Modes 0 and 3, same edges
// - Cycles counted rising edge to rising
// - Dual transfer only by dual read
// - 512 KB, 8 blocks, 128 sectors
// - 256-byte pages, program wraps in page
// - Programming only clears bits
// - Sector, block, chip erase; no page
// - 32 KB and 64 KB block erase
// - Protect pin, lock, block bits guard
// - Readable 128-bit unique identifier
// - Lock and protect low block status write
// - Writes need whole bytes before deselect
// - Busy ignores all but status read
// - Enable latch set by enable, auto-cleared
`timescale 1ns/10ps
`include "sfs_regs.svh"
module sfs_flash_front #(
	parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF_FEDCBA9876543210 // Arbitrary value
) (
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic sck_i,
	input  wire logic cs_n_i,
	input  wire logic wp_n_i,
	input  wire logic serial_in_line_i,
	output logic      dual_lane_zero_o,
	output logic      dual_lane_zero_oe_n_o,
	output logic      dual_lane_one_o,
	output logic      dual_lane_one_oe_n_o,
	output logic      busy_o
);
	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	logic cs_n_lvl, cs_rise, cs_fall;
	logic sck_rise, sck_fall;
	logic din_lvl, wp_n_lvl;
	// Select resets as low: a select held through reset never looks like a new select edge
	sfs_pin_sync #(.RST_VAL(1'b0)) u_cs (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pin_i(cs_n_i),
		.level_o(cs_n_lvl), .rise_o(cs_rise), .fall_o(cs_fall));
	sfs_pin_sync #(.RST_VAL(1'b0)) u_sck (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pin_i(sck_i),
		.level_o(), .rise_o(sck_rise), .fall_o(sck_fall));
	sfs_pin_sync #(.RST_VAL(1'b0)) u_din (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.pin_i(serial_in_line_i), .level_o(din_lvl), .rise_o(), .fall_o());
	sfs_pin_sync #(.RST_VAL(1'b1)) u_wp (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pin_i(wp_n_i),
		.level_o(wp_n_lvl), .rise_o(), .fall_o());
	logic sel;
	assign sel = ~cs_n_lvl; // Selected when chip select low
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] mem [0:`SFS_ARRAY_BYTES-1];
	logic [7:0] page_buf [0:`SFS_PAGE_BYTES-1];
	logic [`SFS_PAGE_BYTES-1:0] page_hit_q;
	logic [7:0] sr_q;
	// ----------------------------------------
	// Shift state
	// ----------------------------------------
	sfs_pkg::sfs_phase_type phase_q;
	sfs_pkg::sfs_job_type   job_q;
	logic        armed_q;
	logic [7:0]  op_q;
	logic [7:0]  sh_q;
	logic [2:0]  bit_q;
	logic [1:0]  abyte_q;
	logic [23:0] addr_q;
	logic [7:0]  wdata_q;
	logic        have_wsr_q;
	logic [7:0]  out_q;
	logic [7:0]  obit_q;
	logic [6:0]  uid_ptr_q;
	logic        dual_q;
	logic        drive_q;
	logic [15:0] busy_cnt_q;
	logic [23:0] job_addr_q;
	logic [7:0]  job_op_q;
	logic [`SFS_PAGE_BYTES-1:0] job_hit_q;
	logic [8:0]  run_q;
	logic [7:0]  byte_in;
	logic        byte_done;
	assign byte_in   = {sh_q[6:0], din_lvl};
	assign byte_done = sel && sck_rise && (bit_q == 3'd7);
	function automatic logic is_write_op(input logic [7:0] op);
		is_write_op = (op == `SFS_OP_PP) || (op == `SFS_OP_SE) || (op == `SFS_OP_BE32) ||
			(op == `SFS_OP_BE64) || (op == `SFS_OP_CE) || (op == `SFS_OP_WRSR);
	endfunction
	function automatic logic needs_addr(input logic [7:0] op);
		needs_addr = (op == `SFS_OP_READ) || (op == `SFS_OP_FREAD) || (op == `SFS_OP_DREAD) ||
			(op == `SFS_OP_PP) || (op == `SFS_OP_SE) || (op == `SFS_OP_BE32) ||
			(op == `SFS_OP_BE64) || (op == `SFS_OP_UID);
	endfunction
	// Address protected by the block bits: lower portions, except setting 4, which also guards blocks 4 and 6
	function automatic logic is_protected(input logic [23:0] a, input logic [2:0] bp);
		logic [18:0] lim;
		lim = 19'h0;
		case (bp)
			3'd0: lim = 19'h00000;
			3'd1: lim = 19'h7E000;
			3'd2: lim = 19'h7C000;
			3'd3: lim = 19'h78000;
			3'd4: lim = 19'h50000;
			3'd5: lim = 19'h20000;
			default: lim = 19'h7FFFF;
		endcase
		is_protected = (bp == 3'd4) ? ((a[18:0] < 19'h30000) || (a[18:16] == 3'd4) || (a[18:16] == 3'd6)) :
			(bp >= 3'd6) ? 1'b1 : (a[18:0] < lim);
	endfunction
	logic busy;
	assign busy   = sr_q[`SFS_SR_BUSY];
	assign busy_o = busy;
	// ----------------------------------------
	// Power-up gate
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			armed_q <= 1'b0;
		end else if (cs_fall) begin
			armed_q <= 1'b1;
		end
	end
	// ----------------------------------------
	// Command decode on rising edges
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase_q    <= sfs_pkg::ST_CMD;
			op_q       <= 8'h00;
			sh_q       <= 8'h00;
			bit_q      <= 3'd0;
			abyte_q    <= 2'd0;
			addr_q     <= 24'h0;
			have_wsr_q <= 1'b0;
			wdata_q    <= 8'h00;
			page_hit_q <= '0;
		end else if (!sel) begin
			phase_q <= sfs_pkg::ST_CMD;
			bit_q   <= 3'd0;
			abyte_q <= 2'd0;
			have_wsr_q <= 1'b0;
			page_hit_q <= '0;
		end else if (sck_rise) begin
			sh_q  <= byte_in;
			bit_q <= bit_q + 3'd1;
			if (byte_done) begin
				case (phase_q)
					sfs_pkg::ST_CMD: begin
						op_q <= byte_in;
						if (!armed_q || (busy && byte_in != `SFS_OP_RDSR)) begin
							phase_q <= sfs_pkg::ST_IGNORE;
						end else if (needs_addr(byte_in)) begin
							phase_q <= sfs_pkg::ST_ADDR;
						end else begin
							phase_q <= sfs_pkg::ST_DATA;
						end
					end
					sfs_pkg::ST_ADDR: begin
						addr_q  <= {addr_q[15:0], byte_in};
						abyte_q <= abyte_q + 2'd1;
						if (abyte_q == 2'd2) begin
							phase_q <= (op_q == `SFS_OP_FREAD || op_q == `SFS_OP_DREAD ||
								op_q == `SFS_OP_UID) ? sfs_pkg::ST_DUMMY : sfs_pkg::ST_DATA;
						end
					end
					sfs_pkg::ST_DUMMY: begin
						if (op_q == `SFS_OP_UID && abyte_q != 2'd3) begin
							abyte_q <= abyte_q + 2'd1;
						end else begin
							phase_q <= sfs_pkg::ST_DATA;
						end
					end
					sfs_pkg::ST_DATA: begin
						if (op_q == `SFS_OP_PP) begin
							page_buf[addr_q[7:0]]   <= byte_in;
							page_hit_q[addr_q[7:0]] <= 1'b1;
							addr_q[7:0] <= addr_q[7:0] + 8'd1;
						end else if (op_q == `SFS_OP_WRSR) begin
							wdata_q    <= byte_in;
							have_wsr_q <= 1'b1;
						end
					end
					default: begin
						phase_q <= sfs_pkg::ST_IGNORE;
					end
				endcase
			end
		end
	end
	// ----------------------------------------
	// Output shifter on falling edges
	// ----------------------------------------
	logic reading;
	assign reading = (phase_q == sfs_pkg::ST_DATA) &&
		(op_q == `SFS_OP_READ || op_q == `SFS_OP_FREAD || op_q == `SFS_OP_DREAD ||
		op_q == `SFS_OP_RDSR || op_q == `SFS_OP_UID);
	logic [18:0] rd_ptr_q;
	logic [18:0] rd_addr;
	assign rd_addr = addr_q[18:0] + rd_ptr_q; // Auto-increment, wraps at array end
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_q     <= 8'h00;
			obit_q    <= 8'h00;
			uid_ptr_q <= 7'd0;
			dual_q    <= 1'b0;
			drive_q   <= 1'b0;
		end else if (!sel) begin
			drive_q   <= 1'b0;
			dual_q    <= 1'b0;
			obit_q    <= 8'h00;
			uid_ptr_q <= 7'd0;
		end else if (sck_fall && reading) begin
			drive_q <= 1'b1;
			dual_q  <= (op_q == `SFS_OP_DREAD);
			if (obit_q == 8'h00) begin
				if (op_q == `SFS_OP_RDSR) begin
					out_q <= sr_q;
				end else if (op_q == `SFS_OP_UID) begin
					out_q     <= UNIQUE_ID[{~uid_ptr_q[3:0], 3'b111} -: 8];
					uid_ptr_q <= uid_ptr_q + 7'd1;
				end else begin
					out_q <= mem[rd_addr];
				end
				obit_q <= (op_q == `SFS_OP_DREAD) ? 8'h03 : 8'h07;
			end else begin
				out_q  <= (op_q == `SFS_OP_DREAD) ? {out_q[5:0], 2'b00} : {out_q[6:0], 1'b0};
				obit_q <= obit_q - 8'd1;
			end
		end
	end
	assign dual_lane_one_o       = out_q[7];
	assign dual_lane_one_oe_n_o  = ~(sel & drive_q);
	assign dual_lane_zero_o      = out_q[6];
	assign dual_lane_zero_oe_n_o = ~(sel & drive_q & dual_q);
	// Read address advance once a byte is handed out
	logic rd_adv;
	assign rd_adv = sel && sck_fall && reading && (obit_q == 8'h00) &&
		(op_q == `SFS_OP_READ || op_q == `SFS_OP_FREAD || op_q == `SFS_OP_DREAD);
	// ----------------------------------------
	// Status register and embedded jobs
	// ----------------------------------------
	logic whole_bytes, wr_ok, lock_hw;
	assign whole_bytes = (bit_q == 3'd0);
	assign lock_hw     = sr_q[`SFS_SR_LOCK] && !wp_n_lvl;
	assign wr_ok       = cs_rise && whole_bytes && (phase_q == sfs_pkg::ST_DATA) &&
		sr_q[`SFS_SR_WLATCH] && !busy;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sr_q       <= `SFS_SR_RESET;
			job_q      <= sfs_pkg::OP_NONE;
			busy_cnt_q <= 16'd0;
			job_addr_q <= 24'h0;
			job_op_q   <= 8'h00;
			job_hit_q  <= '0;
			run_q      <= 9'd0;
		end else if (busy) begin
			if (busy_cnt_q != 16'd0) begin
				busy_cnt_q <= busy_cnt_q - 16'd1;
			end else if (job_q == sfs_pkg::OP_PROG && run_q != 9'd256) begin
				if (job_hit_q[run_q[7:0]]) begin
					mem[{job_addr_q[18:8], run_q[7:0]}] <= mem[{job_addr_q[18:8], run_q[7:0]}] &
						page_buf[run_q[7:0]];
				end
				run_q <= run_q + 9'd1;
			end else if (job_q == sfs_pkg::OP_ERASE && run_q != 9'd256) begin
				run_q <= 9'd256; // Array wipe done below in one step
				for (int i = 0; i < `SFS_ARRAY_BYTES; i++) begin
					if ((job_op_q == `SFS_OP_CE) ||
						(job_op_q == `SFS_OP_SE && i[18:12] == job_addr_q[18:12]) ||
						(job_op_q == `SFS_OP_BE32 && i[18:15] == job_addr_q[18:15]) ||
						(job_op_q == `SFS_OP_BE64 && i[18:16] == job_addr_q[18:16])) begin
						mem[i] <= 8'hFF;
					end
				end
			end else begin
				sr_q[`SFS_SR_BUSY] <= 1'b0;
				sr_q[`SFS_SR_WLATCH] <= 1'b0;
				job_q <= sfs_pkg::OP_NONE;
			end
		end else if (cs_rise && phase_q == sfs_pkg::ST_DATA && whole_bytes) begin
			if (op_q == `SFS_OP_WREN) begin
				sr_q[`SFS_SR_WLATCH] <= 1'b1;
			end else if (op_q == `SFS_OP_WRDI) begin
				sr_q[`SFS_SR_WLATCH] <= 1'b0;
			end else if (wr_ok && op_q == `SFS_OP_WRSR && have_wsr_q && !lock_hw) begin
				sr_q[`SFS_SR_LOCK] <= wdata_q[`SFS_SR_LOCK];
				sr_q[`SFS_SR_BP_HI:`SFS_SR_BP_LO] <= wdata_q[`SFS_SR_BP_HI:`SFS_SR_BP_LO];
				sr_q[`SFS_SR_BUSY] <= 1'b1;
				job_q      <= sfs_pkg::OP_WSR;
				busy_cnt_q <= 16'(`SFS_BUSY_CYC);
				run_q      <= 9'd256;
			end else if (wr_ok && is_write_op(op_q) && op_q != `SFS_OP_WRSR &&
				!is_protected(addr_q, sr_q[`SFS_SR_BP_HI:`SFS_SR_BP_LO]) &&
				(op_q != `SFS_OP_CE || sr_q[`SFS_SR_BP_HI:`SFS_SR_BP_LO] == 3'd0)) begin
				sr_q[`SFS_SR_BUSY] <= 1'b1;
				job_q      <= (op_q == `SFS_OP_PP) ? sfs_pkg::OP_PROG : sfs_pkg::OP_ERASE;
				job_op_q   <= op_q;
				job_addr_q <= addr_q;
				job_hit_q  <= page_hit_q;
				busy_cnt_q <= 16'(`SFS_BUSY_CYC);
				run_q      <= 9'd0;
			end
		end
	end
	// Read offset from the start address, cleared per frame
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_ptr_q <= 19'h0;
		end else if (!sel) begin
			rd_ptr_q <= 19'h0;
		end else if (rd_adv) begin
			rd_ptr_q <= rd_ptr_q + 19'd1;
		end
	end
endmodule // sfs_flash_front

// ### rtl/sfs_pin_sync.sv
// Two-flop synchroniser with edge detect for one pin
`timescale 1ns/10ps
module sfs_pin_sync #(
	parameter logic RST_VAL = 1'b0 // Pin level assumed during reset
) (
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	logic meta_q;
	logic sync_q;
	logic last_q;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
			last_q <= RST_VAL;
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end
	assign level_o = sync_q;
	assign rise_o  = sync_q & ~last_q;
	assign fall_o  = ~sync_q & last_q;
endmodule // sfs_pin_sync

// ### rtl/sfs_pkg.sv
// Types for the serial flash front end
package sfs_pkg;
	typedef enum logic [2:0] {
		ST_CMD,
		ST_ADDR,
		ST_DUMMY,
		ST_DATA,
		ST_IGNORE
	} sfs_phase_type;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_PROG,
		OP_ERASE,
		OP_WSR
	} sfs_job_type;
endpackage

// ### rtl/sfs_regs.svh
// Constants for the serial flash front end
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH
`define SFS_OP_WREN     8'h06
`define SFS_OP_WRDI     8'h04
`define SFS_OP_RDSR     8'h05
`define SFS_OP_WRSR     8'h01
`define SFS_OP_READ     8'h03
`define SFS_OP_FREAD    8'h0B
`define SFS_OP_DREAD    8'h3B
`define SFS_OP_PP       8'h02
`define SFS_OP_SE       8'h20
`define SFS_OP_BE32     8'h52
`define SFS_OP_BE64     8'hD8
`define SFS_OP_CE       8'hC7
`define SFS_OP_UID      8'h4B
`define SFS_ARRAY_BYTES 524288
`define SFS_ADDR_W      19
`define SFS_PAGE_BYTES  256
`define SFS_SR_LOCK     7
`define SFS_SR_BP_HI    4
`define SFS_SR_BP_LO    2
`define SFS_SR_WLATCH   1
`define SFS_SR_BUSY     0
`define SFS_SR_RESET    8'h00
`define SFS_BUSY_US     2
`define SFS_CLK_MHZ     10
`define SFS_BUSY_CYC    (`SFS_BUSY_US * `SFS_CLK_MHZ)
`endif
